/* File: verilog/isa_core.sv */
// How it works
// - single pop moves stack top into file or working register, one cycle, no flags
// - double pop loads Wn and Wn+1 from stack in two cycles, no flags
// - single push of file or working register, one cycle, no flags
// - double push stores Wn and Wn+1 in two cycles, no flags
// - repeat by literal runs next instruction literal plus one times; one cycle
// - repeat by register runs next instruction register plus one times
// - power save enters sleep or idle per literal; clears watchdog flag, sets sleep or idle flag
// - return with literal loads 10-bit literal into Wn; six or five cycles
// - rotate left via carry, updates carry, negative, zero; one cycle
// - plain rotate left updates only negative and zero; one cycle
// - rotate right via carry, updates carry, negative, zero; one cycle
// - plain rotate right updates only negative and zero; one cycle
// - sign extend into destination, updates carry, negative, zero; one cycle
// - accumulator shift by register amount, updates the selected accumulator's overflow and saturation flags
// - accumulator shift by signed 6-bit literal, same flags
// - pop, push, rotate or register negate with a peripheral target costs one extra cycle
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
module isa_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int DW = isa_pkg::DATA_W;
  localparam int AW = isa_pkg::ACC_W;

  logic [31:0] instr_q;
  isa_pkg::operand_t opnd_q;
  logic [DW-1:0] wreg_q [isa_pkg::NUM_WREG];
  logic [DW-1:0] stack_q [isa_pkg::STACK_DEPTH];
  logic [3:0] sp_q;
  logic [AW-1:0] acca_q, accb_q;
  logic [DW-1:0] result_q;
  logic [2:0] cyc_q;
  logic busy_q;
  logic [14:0] rpt_q;
  logic rpt_arm_q;
  logic c_q, dc_q, n_q, ov_q, z_q, sfa_q, watchdog_timeout_flag_q, sleep_q, idle_q;
  logic oa_q, ob_q, sa_q, sb_q;

  wire isa_pkg::opcode_t op = isa_pkg::opcode_t'(instr_q[isa_pkg::F_OP_LSB +: 5]);
  wire logic [3:0] dst = instr_q[isa_pkg::F_DST_LSB +: 4];
  wire logic [3:0] srcr = instr_q[isa_pkg::F_SRC_LSB +: 4];
  wire logic [14:0] lit = instr_q[isa_pkg::F_LIT_LSB +: 15];
  wire logic dst_file = instr_q[30];
  wire logic accsel = instr_q[isa_pkg::F_ACCSEL];

  // bus access decode
  wire logic wr = psel && penable && pwrite;
  wire logic rd_en = psel && !penable && !pwrite;
  wire logic issue = wr && (paddr == isa_pkg::OFS_INSTR) && !busy_q;

  // cycle count per instruction
  function automatic logic [2:0] cycles(input isa_pkg::opcode_t o, input logic shrt,
                                        input logic sfr);
    logic [2:0] n;
    n = isa_pkg::CYC_ONE;
    unique case (o)
      isa_pkg::OP_POP_D, isa_pkg::OP_PUSH_D: n = isa_pkg::CYC_TWO;
      isa_pkg::OP_RET_LIT, isa_pkg::OP_RET_SUB, isa_pkg::OP_RET_INT:
        n = shrt ? isa_pkg::CYC_RET_SHORT : isa_pkg::CYC_RET_LONG;
      default: n = isa_pkg::CYC_ONE;
    endcase
    if (sfr && (o == isa_pkg::OP_POP || o == isa_pkg::OP_PUSH || o inside
        {[isa_pkg::OP_ROT_LC:isa_pkg::OP_ROT_RP], isa_pkg::OP_NEG_REG}))
      n = 3'(n + isa_pkg::CYC_SFR_EXTRA);
    return n;
  endfunction

  // operand for word units
  wire logic [DW-1:0] src_val = dst_file ? opnd_q.file_val : wreg_q[srcr];
  logic [DW-1:0] rot_res;
  isa_pkg::alu_flags_t rf;
  rot_unit #(.W(DW)) u_rot (
    .src(src_val),
    .carry_in(c_q),
    .op(op),
    .res(rot_res),
    .flags(rf)
  );

  wire logic [AW-1:0] acc_sel = accsel ? accb_q : acca_q;
  wire logic [5:0] amt = (op == isa_pkg::OP_ACC_SHIFT_REG) ? wreg_q[srcr][5:0] : lit[5:0];
  logic [AW-1:0] acc_sh;
  logic sh_ov, sh_sat;
  acc_shifter #(.AW(AW)) u_acc (
    .acc_in(acc_sel),
    .amount(amt),
    .acc_out(acc_sh),
    .overflow(sh_ov),
    .clamped(sh_sat)
  );
  wire logic [AW-1:0] acc_neg = AW'(~acc_sel + 1'b1);
  wire logic neg_ov = (acc_neg[AW-1:AW-9] != {9{acc_neg[AW-1]}});

  wire logic last = busy_q && (cyc_q == 3'h1);

  // cycle counter and repeat engine
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      cyc_q <= 3'h0;
      rpt_q <= 15'h0000;
      rpt_arm_q <= 1'b0;
    end else if (issue) begin
      busy_q <= 1'b1;
      cyc_q <= cycles(isa_pkg::opcode_t'(pwdata[4:0]), opnd_q.ret_short, opnd_q.sfr_target);
    end else if (busy_q) begin
      cyc_q <= 3'(cyc_q - 3'h1);
      if (last) begin
        if (op == isa_pkg::OP_REPEAT_LIT) begin
          rpt_q <= lit;
          rpt_arm_q <= 1'b1;
        end else if (op == isa_pkg::OP_REPEAT_REG) begin
          rpt_q <= wreg_q[srcr][14:0];
          rpt_arm_q <= 1'b1;
        end else if (rpt_arm_q && rpt_q != 15'h0000) begin
          rpt_q <= 15'(rpt_q - 15'h0001); // rerun next instruction
          cyc_q <= cycles(op, opnd_q.ret_short, opnd_q.sfr_target);
        end else begin
          rpt_arm_q <= 1'b0;
          busy_q <= 1'b0;
        end
        if (op == isa_pkg::OP_REPEAT_LIT || op == isa_pkg::OP_REPEAT_REG)
          busy_q <= 1'b0;
      end
    end
  end

  // register file, stack and result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp_q <= 4'h0;
      result_q <= 16'h0000;
      for (int i = 0; i < isa_pkg::NUM_WREG; i++) wreg_q[i] <= 16'h0000;
      for (int i = 0; i < isa_pkg::STACK_DEPTH; i++) stack_q[i] <= 16'h0000;
    end else if (wr && paddr >= isa_pkg::OFS_WREG && !busy_q) begin
      wreg_q[paddr[5:2]] <= pwdata[15:0];
    end else if (busy_q) begin
      unique case (op)
        isa_pkg::OP_POP: if (last) begin
          sp_q <= 4'(sp_q - 4'h1);
          if (dst_file) result_q <= stack_q[4'(sp_q - 4'h1)];
          else wreg_q[dst] <= stack_q[4'(sp_q - 4'h1)];
        end
        isa_pkg::OP_POP_D: begin // two cycles, Wn+1 first
          sp_q <= 4'(sp_q - 4'h1);
          wreg_q[4'(dst + (cyc_q == 3'h2 ? 4'h1 : 4'h0))] <= stack_q[4'(sp_q - 4'h1)];
        end
        isa_pkg::OP_PUSH: if (last) begin
          stack_q[sp_q] <= src_val;
          sp_q <= 4'(sp_q + 4'h1);
        end
        isa_pkg::OP_PUSH_D: begin // Wn then Wn+1
          stack_q[sp_q] <= wreg_q[4'(srcr + (cyc_q == 3'h1 ? 4'h1 : 4'h0))];
          sp_q <= 4'(sp_q + 4'h1);
        end
        isa_pkg::OP_RET_LIT: if (last) wreg_q[dst] <= {6'h00, lit[9:0]};
        isa_pkg::OP_ROT_LC, isa_pkg::OP_ROT_LP, isa_pkg::OP_ROT_RC, isa_pkg::OP_ROT_RP,
        isa_pkg::OP_NEG_REG: if (last) begin
          if (dst_file) result_q <= rot_res;
          else wreg_q[dst] <= rot_res;
        end
        isa_pkg::OP_SIGN_EXT: if (last) wreg_q[dst] <= rot_res;
        default: ;
      endcase
    end
  end

  // core flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {c_q, dc_q, n_q, ov_q, z_q} <= 5'h00;
      {sfa_q, watchdog_timeout_flag_q, sleep_q, idle_q} <= 4'h0;
    end else if (last) begin
      unique case (op)
        isa_pkg::OP_ROT_LC, isa_pkg::OP_ROT_RC, isa_pkg::OP_SIGN_EXT:
          {c_q, n_q, z_q} <= {rf.c, rf.n, rf.z};
        isa_pkg::OP_ROT_LP, isa_pkg::OP_ROT_RP:
          {n_q, z_q} <= {rf.n, rf.z};
        isa_pkg::OP_NEG_REG: {c_q, dc_q, n_q, ov_q, z_q} <= rf;
        isa_pkg::OP_POWER_SAVE: begin
          watchdog_timeout_flag_q <= 1'b0;
          sleep_q <= !lit[0];
          idle_q <= lit[0];
        end
        isa_pkg::OP_RET_LIT, isa_pkg::OP_RET_SUB, isa_pkg::OP_RET_INT:
          sfa_q <= 1'b0;
        default: ;
      endcase
    end
  end

  // accumulators and their flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acca_q <= 40'h00_0000_0000;
      accb_q <= 40'h00_0000_0000;
      {oa_q, ob_q, sa_q, sb_q} <= 4'h0;
    end else if (wr && !busy_q && paddr == isa_pkg::OFS_ACCA_LO) begin
      acca_q <= {{8{pwdata[31]}}, pwdata};
    end else if (wr && !busy_q && paddr == isa_pkg::OFS_ACCB_LO) begin
      accb_q <= {{8{pwdata[31]}}, pwdata};
    end else if (last && (op == isa_pkg::OP_ACC_SHIFT_REG || op == isa_pkg::OP_ACC_SHIFT_IMM
                          || op == isa_pkg::OP_NEG_ACC)) begin
      if (accsel) begin
        accb_q <= (op == isa_pkg::OP_NEG_ACC) ? acc_neg : acc_sh;
        ob_q <= (op == isa_pkg::OP_NEG_ACC) ? neg_ov : sh_ov;
        sb_q <= (op == isa_pkg::OP_NEG_ACC) ? 1'b0 : sh_sat;
      end else begin
        acca_q <= (op == isa_pkg::OP_NEG_ACC) ? acc_neg : acc_sh;
        oa_q <= (op == isa_pkg::OP_NEG_ACC) ? neg_ov : sh_ov;
        sa_q <= (op == isa_pkg::OP_NEG_ACC) ? 1'b0 : sh_sat;
      end
    end
  end

  // instruction and operand registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      instr_q <= 32'h0000_0000;
      opnd_q <= '0;
    end else if (issue) begin
      instr_q <= pwdata;
    end else if (wr && !busy_q && paddr == isa_pkg::OFS_OPND) begin
      opnd_q <= pwdata[17:0];
    end
  end

  // read mux, registered in the setup cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      prdata <= 32'h0000_0000;
      if (paddr >= isa_pkg::OFS_WREG) prdata <= {16'h0000, wreg_q[paddr[5:2]]};
      else unique case (paddr)
        isa_pkg::OFS_INSTR: prdata <= instr_q;
        isa_pkg::OFS_OPND: prdata <= {14'h0000, opnd_q};
        isa_pkg::OFS_STATUS: prdata <= {15'h0000, rpt_arm_q, busy_q, sa_q | sb_q, sb_q, sa_q,
          oa_q | ob_q, ob_q, oa_q, idle_q, sleep_q, watchdog_timeout_flag_q, sfa_q, z_q, ov_q, n_q, dc_q, c_q};
        isa_pkg::OFS_RESULT: prdata <= {16'h0000, result_q};
        isa_pkg::OFS_ACCA_LO: prdata <= acca_q[31:0];
        isa_pkg::OFS_ACCB_LO: prdata <= accb_q[31:0];
        isa_pkg::OFS_ACC_HI: prdata <= {8'h00, accb_q[39:32], 8'h00, acca_q[39:32]};
        isa_pkg::OFS_REPEAT: prdata <= {17'h00000, rpt_q};
        isa_pkg::OFS_SP: prdata <= {28'h0000000, sp_q};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && pwrite && busy_q && (paddr == isa_pkg::OFS_INSTR);

  // execution checks beside the cycle, stack and flag logic
  chk_pop_flags: assert property (@(posedge mclk) disable iff (rst)
    last && op == isa_pkg::OP_POP |=> $stable({c_q, n_q, z_q})) else $error("pop flags");
  chk_popd_len: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy_q) && op == isa_pkg::OP_POP_D && !opnd_q.sfr_target |-> cyc_q == 3'h2)
    else $error("double pop length");
  chk_push_sp: assert property (@(posedge mclk) disable iff (rst)
    last && op == isa_pkg::OP_PUSH |=> sp_q == 4'($past(sp_q) + 4'h1))
    else $error("push pointer");
  chk_pushd_sp: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy_q) && op == isa_pkg::OP_PUSH_D |-> ##2 sp_q == 4'($past(sp_q, 2) + 4'h2))
    else $error("double push pointer");
  chk_rpt_load: assert property (@(posedge mclk) disable iff (rst)
    last && op == isa_pkg::OP_REPEAT_LIT |=> rpt_q == $past(lit) && !busy_q)
    else $error("repeat load");
  chk_rot_lc: assert property (@(posedge mclk) disable iff (rst)
    last && op == isa_pkg::OP_ROT_LC |=> c_q == $past(src_val[DW-1]))
    else $error("rotate carry");
  chk_plain_c: assert property (@(posedge mclk) disable iff (rst)
    last && (op == isa_pkg::OP_ROT_LP || op == isa_pkg::OP_ROT_RP) |=> $stable(c_q))
    else $error("plain rotate carry");
  chk_ret_len: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy_q) && op == isa_pkg::OP_RET_SUB && !opnd_q.ret_short |-> cyc_q == 3'h6)
    else $error("return length");
  chk_pwr_sleep: assert property (@(posedge mclk) disable iff (rst)
    last && op == isa_pkg::OP_POWER_SAVE |=> sleep_q == !$past(lit[0]))
    else $error("power save mode");
  chk_sfr_extra: assert property (@(posedge mclk) disable iff (rst)
    $rose(busy_q) && op == isa_pkg::OP_ROT_LC && opnd_q.sfr_target |-> cyc_q == 3'h2)
    else $error("peripheral extra cycle");
  chk_acc_ov: assert property (@(posedge mclk) disable iff (rst)
    last && op == isa_pkg::OP_ACC_SHIFT_REG && !accsel |=> oa_q == $past(sh_ov))
    else $error("shift overflow flag");
  // main scenarios reached
  cov_popd: cover property (@(posedge mclk) disable iff (rst) last && op == isa_pkg::OP_POP_D);
  cov_rpt: cover property (@(posedge mclk) disable iff (rst) rpt_arm_q && last);
  cov_acc: cover property (@(posedge mclk) disable iff (rst) last && sh_sat);
  cov_sfr: cover property (@(posedge mclk) disable iff (rst) $rose(busy_q) && opnd_q.sfr_target);
endmodule

/* File: verilog/isa_pkg.sv */
package isa_pkg;
  // data and accumulator widths, working register count and stack depth
  localparam int DATA_W = 16;
  localparam int ACC_W = 40;
  localparam int NUM_WREG = 16;
  localparam int STACK_DEPTH = 16;

  // execution cycle counts
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_RET_LONG = 3'h6;
  localparam logic [2:0] CYC_RET_SHORT = 3'h5;
  localparam logic [2:0] CYC_SFR_EXTRA = 3'h1;

  // register offsets on the bus
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_ACCA_LO = 8'h10;
  localparam logic [7:0] OFS_ACCB_LO = 8'h14;
  localparam logic [7:0] OFS_ACC_HI = 8'h18;
  localparam logic [7:0] OFS_REPEAT = 8'h1C;
  localparam logic [7:0] OFS_SP = 8'h20;
  localparam logic [7:0] OFS_WREG = 8'h40;

  // instruction register field positions
  localparam int F_OP_LSB = 0;
  localparam int F_DST_LSB = 8;
  localparam int F_SRC_LSB = 12;
  localparam int F_LIT_LSB = 16;
  localparam int F_ACCSEL = 31;

  // status register bit positions
  localparam int S_C = 0;
  localparam int S_DC = 1;
  localparam int S_N = 2;
  localparam int S_OV = 3;
  localparam int S_Z = 4;
  localparam int S_SFA = 5;
  localparam int S_WATCHDOG_TIMEOUT_FLAG = 6;
  localparam int S_SLEEP = 7;
  localparam int S_IDLE = 8;
  localparam int S_OA = 9;
  localparam int S_OB = 10;
  localparam int S_OAB = 11;
  localparam int S_SA = 12;
  localparam int S_SB = 13;
  localparam int S_SAB = 14;
  localparam int S_BUSY = 15;
  localparam int S_REPEAT = 16;

  typedef enum logic [4:0] {
    OP_NOP, OP_POP, OP_POP_D, OP_PUSH, OP_PUSH_D, OP_REPEAT_LIT, OP_REPEAT_REG,
    OP_POWER_SAVE, OP_RET_LIT, OP_RET_SUB, OP_RET_INT, OP_ROT_LC, OP_ROT_LP,
    OP_ROT_RC, OP_ROT_RP, OP_SIGN_EXT, OP_ACC_SHIFT_REG, OP_ACC_SHIFT_IMM,
    OP_NEG_REG, OP_NEG_ACC, OP_SOFT_RESET
  } opcode_t;

  // operand register contents as one group
  typedef struct packed {
    logic sfr_target;
    logic ret_short;
    logic [15:0] file_val;
  } operand_t;

  // flags produced by the shift/rotate unit
  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
  } alu_flags_t;
endpackage

/* File: verilog/rot_unit.sv */
module rot_unit #(
  parameter int W = 16
) (
  input wire logic [isa_pkg::DATA_W-1:0] src,
  input wire logic carry_in,
  input wire isa_pkg::opcode_t op,
  output logic [isa_pkg::DATA_W-1:0] res,
  output isa_pkg::alu_flags_t flags
);
  // rotate, sign extend and negate on one word
  always_comb begin
    res = src;
    flags = '0;
    flags.c = carry_in;
    unique case (op)
      isa_pkg::OP_ROT_LC: begin
        res = {src[W-2:0], carry_in};
        flags.c = src[W-1];
      end
      isa_pkg::OP_ROT_LP: res = {src[W-2:0], src[W-1]};
      isa_pkg::OP_ROT_RC: begin
        res = {carry_in, src[W-1:1]};
        flags.c = src[0];
      end
      isa_pkg::OP_ROT_RP: res = {src[0], src[W-1:1]};
      isa_pkg::OP_SIGN_EXT: begin
        res = {{(W-8){src[7]}}, src[7:0]};
        flags.c = ~src[7];
      end
      isa_pkg::OP_NEG_REG: begin
        res = W'(~src + 1'b1);
        flags.c = (src == '0);
        flags.dc = (src[3:0] == 4'h0);
        flags.ov = (src == {1'b1, {(W-1){1'b0}}});
      end
      default: res = src;
    endcase
    flags.n = res[W-1];
    flags.z = (res == '0);
  end
endmodule

/* File: verilog/acc_shifter.sv */
module acc_shifter #(
  parameter int AW = 40
) (
  input wire logic [AW-1:0] acc_in,
  input wire logic [5:0] amount,
  output logic [AW-1:0] acc_out,
  output logic overflow,
  output logic clamped
);
  logic signed [AW-1:0] sacc;
  logic signed [AW:0] wide;
  logic signed [5:0] samt;
  // positive amount shifts right, negative shifts left
  always_comb begin
    sacc = $signed(acc_in);
    samt = $signed(amount);
    if (samt >= 0) begin
      wide = $signed({sacc[AW-1], sacc}) >>> samt; // concatenation alone is unsigned
    end else begin
      wide = {sacc[AW-1], sacc} <<< (-samt);
    end
    overflow = (wide[AW-1:AW-9] != {9{wide[AW-1]}});
    clamped = (wide[AW] != wide[AW-1]) || ((samt < 0) && ((sacc <<< (-samt)) >>> (-samt)) != sacc);
    if (clamped) begin
      acc_out = sacc[AW-1] ? {1'b1, {(AW-1){1'b0}}} : {1'b0, {(AW-1){1'b1}}};
    end else begin
      acc_out = wide[AW-1:0];
    end
  end
endmodule

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    isa_pkg::opcode_t op;
    logic [15:0] val;
    logic [15:0] res;
    logic [4:0] st;
    logic [4:0] msk;
  } row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic er;
  logic [31:0] sp0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  row_t rows [11];

  isa_core u_isa_core (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // free-running clock
  initial begin
    forever #5 mclk = ~mclk;
  end

  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer, answer taken at the rising edge that shows pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wreg(input int n, input logic [15:0] v);
    apb(1'b1, isa_pkg::OFS_WREG + 8'(4 * n), {16'h0, v});
  endtask

  function automatic logic [31:0] ins(input isa_pkg::opcode_t op, input logic [3:0] s,
      input logic [3:0] d, input logic [14:0] lit, input logic acc);
    return {acc, lit, s, d, 3'h0, op};
  endfunction

  // poll busy until it drops; only the hang guard ends a stuck poll
  task automatic wait_idle();
    do begin
      apb(1'b0, isa_pkg::OFS_STATUS, 32'h0);
    end while (rd[15] !== 1'b0);
  endtask

  task automatic run(input logic [31:0] i, input logic [31:0] o);
    apb(1'b1, isa_pkg::OFS_OPND, o);
    apb(1'b1, isa_pkg::OFS_INSTR, i);
    wait_idle();
  endtask

  // probe with a refused write at edge n, then status at edge n+1
  task automatic cyc(input logic [31:0] i, input logic [31:0] o, input int n);
    apb(1'b1, isa_pkg::OFS_OPND, o);
    apb(1'b1, isa_pkg::OFS_INSTR, i);
    if (n > 2) idle(n - 2);
    apb(1'b1, isa_pkg::OFS_INSTR, 32'h0);
    check({31'h0, er}, {31'h0, n > 1});
    if (n > 1) begin
      apb(1'b0, isa_pkg::OFS_STATUS, 32'h0);
      check({31'h0, rd[15]}, 32'h0);
    end
    wait_idle();
  endtask

  initial begin
    // op, source, result, {z,ov,n,dc,c}, mask
    rows = '{
      '{isa_pkg::OP_ROT_LC, 16'h8001, 16'h0002, 5'h01, 5'h15},
      '{isa_pkg::OP_ROT_LP, 16'h0000, 16'h0000, 5'h11, 5'h15},
      '{isa_pkg::OP_ROT_LC, 16'h4000, 16'h8001, 5'h04, 5'h15},
      '{isa_pkg::OP_ROT_RC, 16'h0001, 16'h0000, 5'h11, 5'h15},
      '{isa_pkg::OP_ROT_RP, 16'h0001, 16'h8000, 5'h05, 5'h15},
      '{isa_pkg::OP_ROT_RC, 16'h0002, 16'h8001, 5'h04, 5'h15},
      '{isa_pkg::OP_ROT_LP, 16'h8000, 16'h0001, 5'h00, 5'h15},
      '{isa_pkg::OP_SIGN_EXT, 16'h1280, 16'hFF80, 5'h04, 5'h14},
      '{isa_pkg::OP_SIGN_EXT, 16'h007F, 16'h007F, 5'h00, 5'h14},
      '{isa_pkg::OP_NEG_REG, 16'h0001, 16'hFFFF, 5'h04, 5'h14},
      '{isa_pkg::OP_NEG_REG, 16'h0000, 16'h0000, 5'h10, 5'h14}};
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // reset values and unmapped place
    rdreg(isa_pkg::OFS_STATUS, 32'h0);
    rdreg(isa_pkg::OFS_RESULT, 32'h0);
    rdreg(isa_pkg::OFS_WREG, 32'h0);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF);
    rdreg(8'h24, 32'h0);
    $display("test reset done");
    // rotate, sign extend and negate table, carry chained from reset
    foreach (rows[r]) begin
      wreg(1, rows[r].val);
      run(ins(rows[r].op, 4'h1, 4'h2, 15'h0, 1'b0), 32'h0);
      rdreg(isa_pkg::OFS_WREG + 8'h08,
            {16'h0, rows[r].res});
      apb(1'b0, isa_pkg::OFS_STATUS, 32'h0);
      check({27'h0, rd[4:0] & rows[r].msk},
            {27'h0, rows[r].st & rows[r].msk});
    end
    $display("test table done");
    // stack round trip leaves flags and pointer alone
    apb(1'b0, isa_pkg::OFS_SP, 32'h0);
    sp0 = rd;
    wreg(3, 16'h1234);
    wreg(4, 16'hABCD);
    wreg(5, 16'h5555);
    run(ins(isa_pkg::OP_PUSH, 4'h5, 4'h0, 15'h0, 1'b0), 32'h0);
    run(ins(isa_pkg::OP_PUSH_D, 4'h3, 4'h0, 15'h0, 1'b0), 32'h0);
    run(ins(isa_pkg::OP_POP_D, 4'h0, 4'h6, 15'h0, 1'b0), 32'h0);
    run(ins(isa_pkg::OP_POP, 4'h0, 4'h8, 15'h0, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_WREG + 8'h18, 32'h1234);
    rdreg(isa_pkg::OFS_WREG + 8'h1C, 32'hABCD);
    rdreg(isa_pkg::OFS_WREG + 8'h20, 32'h5555);
    rdreg(isa_pkg::OFS_SP, sp0);
    apb(1'b0, isa_pkg::OFS_STATUS, 32'h0);
    check({27'h0, rd[4:0]}, 32'h13); // negate of zero left z, dc, c
    $display("test stack done");
    // repeat by literal and by register
    wreg(1, 16'h0001);
    run(ins(isa_pkg::OP_REPEAT_LIT, 4'h0, 4'h0, 15'h0002, 1'b0), 32'h0);
    run(ins(isa_pkg::OP_ROT_LP, 4'h1, 4'h1, 15'h0, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_WREG + 8'h04, 32'h0008);
    wreg(1, 16'h0001);
    wreg(9, 16'h0003);
    run(ins(isa_pkg::OP_REPEAT_REG, 4'h9, 4'h0, 15'h0, 1'b0), 32'h0);
    run(ins(isa_pkg::OP_ROT_LP, 4'h1, 4'h1, 15'h0, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_WREG + 8'h04, 32'h0010);
    $display("test repeat done");
    // accumulator shifts, both directions, overflow, second accumulator
    apb(1'b1, isa_pkg::OFS_ACCA_LO, 32'h0000_0100);
    run(ins(isa_pkg::OP_ACC_SHIFT_IMM, 4'h0, 4'h0, 15'h0004, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h0000_0010);
    run(ins(isa_pkg::OP_ACC_SHIFT_IMM, 4'h0, 4'h0, 15'h003C, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h0000_0100);
    wreg(11, 16'h0002);
    run(ins(isa_pkg::OP_ACC_SHIFT_REG, 4'hB, 4'h0, 15'h0, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h0000_0040);
    apb(1'b1, isa_pkg::OFS_ACCA_LO, 32'h4000_0000);
    run(ins(isa_pkg::OP_ACC_SHIFT_IMM, 4'h0, 4'h0, 15'h003F, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h8000_0000);
    apb(1'b0, isa_pkg::OFS_STATUS, 32'h0);
    check(rd & 32'h1A00, 32'h0A00);
    apb(1'b1, isa_pkg::OFS_ACCB_LO, 32'h0000_0100);
    run(ins(isa_pkg::OP_ACC_SHIFT_IMM, 4'h0, 4'h0, 15'h0001, 1'b1), 32'h0);
    rdreg(isa_pkg::OFS_ACCB_LO, 32'h0000_0080);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h8000_0000);
    apb(1'b1, isa_pkg::OFS_ACCA_LO, 32'hFFFF_FF00);
    run(ins(isa_pkg::OP_ACC_SHIFT_IMM, 4'h0, 4'h0, 15'h0004, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_ACC_HI, 32'h0000_00FF); // sign kept on right shift
    rdreg(isa_pkg::OFS_ACCA_LO, 32'hFFFF_FFF0);
    $display("test accumulator done");
    // return with literal, power save modes
    run(ins(isa_pkg::OP_RET_LIT, 4'h0, 4'hA, 15'h02AB, 1'b0), 32'h0);
    rdreg(isa_pkg::OFS_WREG + 8'h28, 32'h02AB);
    run(ins(isa_pkg::OP_POWER_SAVE, 4'h0, 4'h0, 15'h0001, 1'b0), 32'h0);
    check(rd & 32'h0140, 32'h0100);
    run(ins(isa_pkg::OP_POWER_SAVE, 4'h0, 4'h0, 15'h0000, 1'b0), 32'h0);
    check(rd & 32'h00C0, 32'h0080);
    $display("test return and power done");
    // execution lengths, extra cycle for peripheral targets
    cyc(ins(isa_pkg::OP_NOP, 4'h0, 4'h0, 15'h0, 1'b0), 32'h0, 1);
    cyc(ins(isa_pkg::OP_PUSH, 4'h5, 4'h0, 15'h0, 1'b0), 32'h0, 1);
    cyc(ins(isa_pkg::OP_POP, 4'h0, 4'h8, 15'h0, 1'b0), 32'h0, 1);
    cyc(ins(isa_pkg::OP_PUSH_D, 4'h3, 4'h0, 15'h0, 1'b0), 32'h0, 2);
    cyc(ins(isa_pkg::OP_POP_D, 4'h0, 4'h6, 15'h0, 1'b0), 32'h0, 2);
    // operand bit 17 marks a peripheral target, bit 16 the short return
    cyc(ins(isa_pkg::OP_ROT_LC, 4'h1, 4'h2, 15'h0, 1'b0), 32'h2_0000, 2);
    cyc(ins(isa_pkg::OP_NEG_REG, 4'h1, 4'h2, 15'h0, 1'b0), 32'h2_0000, 2);
    cyc(ins(isa_pkg::OP_PUSH, 4'h5, 4'h0, 15'h0, 1'b0), 32'h2_0000, 2);
    cyc(ins(isa_pkg::OP_POP, 4'h0, 4'h8, 15'h0, 1'b0), 32'h2_0000, 2);
    cyc(ins(isa_pkg::OP_ROT_RP, 4'h1, 4'h2, 15'h0, 1'b0), 32'h0, 1);
    cyc(ins(isa_pkg::OP_NEG_ACC, 4'h0, 4'h0, 15'h0, 1'b0), 32'h0, 1);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h0000_0010);
    cyc(ins(isa_pkg::OP_RET_SUB, 4'h0, 4'h0, 15'h0, 1'b0), 32'h0, 6);
    cyc(ins(isa_pkg::OP_RET_INT, 4'h0, 4'h0, 15'h0, 1'b0), 32'h1_0000, 5);
    cyc(ins(isa_pkg::OP_RET_LIT, 4'h0, 4'hA, 15'h0001, 1'b0), 32'h0, 6);
    cyc(ins(isa_pkg::OP_RET_LIT, 4'h0, 4'hA, 15'h0001, 1'b0), 32'h1_0000, 5);
    cyc(ins(isa_pkg::OP_SOFT_RESET, 4'h0, 4'h0, 15'h0, 1'b0), 32'h0, 1);
    $display("test cycles done");
    // reset in mid-run clears registers, accumulators and flags
    idle(1);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdreg(isa_pkg::OFS_WREG + 8'h28, 32'h0);
    rdreg(isa_pkg::OFS_ACCA_LO, 32'h0);
    rdreg(isa_pkg::OFS_STATUS, 32'h0);
    $display("test reset in run done");
    idle(2);
    conclude();
  end
endmodule
